//--- logic/icm_port.sv
// Connection manager and data path of one interconnect port.
// Client and transport logic share i_clock; the two line inputs are pins.
// Functional notes
// - Connect is legal only when idle or awaiting; port-in-use when open, else not-in-allowed-state.
// - Connect taken while awaiting moves to the opening state.
// - One connection per port; repeat connect or listen gets port-in-use.
// - Serial port ignores remote port; bad local or remote port rejected.
// - Connect refused by the peer answers connection-refused.
// - No presence line or link signal answers no-physical-connection.
// - Listen is legal only when idle; port-in-use when open, else not-in-allowed-state.
// - Listen with remote port accepts only that peer, else any.
// - Connected indication only follows a connect or listen.
// - Send and receive outside the open state answer not-connected.
// - Transmit buffers leave in request order, never interleaved.
// - Good send response only after all characters are copied in.
// - Send after disconnect or with wrong connection is invalid-connection.
// - Too little space is out-of-resources; bad buffer is invalid-buffer.
// - A second receive before received indication gets receive-pending.
// - Received count never exceeds the receive maximum.
// - Deliveries need not match send boundaries.
// - No received indication after disconnected until reconnected.
// - Disconnected waits until received characters are handed over.
// - Disconnect legal when awaiting, opening or open; else not-allowed. While opening, a disconnect waits until the peer answers.
// - Presence drop may, link signal loss must, close the connection.
// - Serial port opens at once, silent on the link, connected at once.
// - Disconnected indication carries a reason code.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Transmit FIFO
module icm_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic                  i_clock,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_flush,
  input  wire logic                  i_valid,
  input  wire logic [W-1:0]          i_data,
  output logic                       o_ready,
  output logic                       o_valid,
  output logic [W-1:0]               o_data,
  input  wire logic                  i_ready,
  output logic [$clog2(D):0]         o_free
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wr;
    logic [AW-1:0]       rd;
    logic [AW:0]         cnt;
  } fifo_s;
  fifo_s r, s;
  logic push, pop;

  // Handshakes straight from the count
  assign o_ready = (r.cnt != (AW+1)'(D));
  assign o_valid = (r.cnt != '0);
  assign o_data  = r.mem[r.rd];
  assign o_free  = (AW+1)'(D) - r.cnt;
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;
  // Next state; flush beats any push or pop
  always_comb begin
    s = r;
    if (push) begin
      s.mem[r.wr] = i_data;
      s.wr = AW'(r.wr + 1'b1);
    end
    if (pop) s.rd = AW'(r.rd + 1'b1);
    s.cnt = (AW+1)'(r.cnt + push - pop);
    if (i_flush) begin
      s.wr  = '0;
      s.rd  = '0;
      s.cnt = '0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) r <= '0;
    else          r <= s;
  end
endmodule : icm_fifo

// ==========================================================
// Connection manager
module icm_port
  import icm_pkg::*;
#(
  parameter bit                P_NETWORK_VARIANT_PORT = 1'b0,
  parameter logic [W_PORT-1:0] P_LOCAL_PORT           = 4'h1,
  parameter bit                P_DROP_ON_PRESENCE     = 1'b1,
  parameter int                P_DEPTH                = FIFO_DEPTH
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  input  wire logic              i_req_valid,
  input  wire icm_req_s          i_req,
  output logic                   o_req_ready,
  output logic                   o_rsp_valid,
  output icm_rsp_e               o_rsp_code,
  output logic                   o_conn_ind,
  output logic [W_CONN-1:0]      o_conn_id,
  output logic                   o_disc_ind,
  output icm_reason_e            o_disc_reason,
  input  wire logic              i_cd_valid,
  input  wire logic [W_CHAR-1:0] i_cd_data,
  output logic                   o_cd_ready,
  output logic                   o_link_valid,
  output logic [W_CHAR-1:0]      o_link_data,
  input  wire logic              i_link_ready,
  input  wire logic              i_rx_valid,
  input  wire logic [W_CHAR-1:0] i_rx_data,
  output logic                   o_rx_ready,
  output logic                   o_rd_valid,
  output logic [W_CHAR-1:0]      o_rd_data,
  output logic                   o_rcvd_ind,
  output logic [W_SIZE-1:0]      o_rcvd_count,
  input  wire logic              i_drive_side_presence_line_alt,
  input  wire logic              i_link_signal,
  input  wire logic              i_peer_accept,
  input  wire logic              i_peer_refuse,
  input  wire logic              i_peer_call,
  input  wire logic [W_PORT-1:0] i_peer_rport,
  input  wire logic              i_peer_closed
);
  icm_st_s r, s;
  logic take, phys_ok, flush, fifo_rdy, in_ok, rv;
  logic [$clog2(P_DEPTH):0] free;
  icm_rsp_e rc;

  function automatic logic conn_match(input icm_req_s q, input icm_st_s t);
    return q.conn == t.conn_id;
  endfunction

  // Requests wait while a copy or a peer answer is outstanding
  assign o_req_ready = !r.copy && !r.peer;
  assign take        = i_req_valid && o_req_ready;
  assign o_cd_ready  = r.copy && fifo_rdy;
  assign in_ok       = i_cd_valid && o_cd_ready;
  assign o_rx_ready  = (r.st == state_link_open) && r.rcv_pend && !r.closing
                       && (r.rcv_cnt < r.rcv_max);
  assign phys_ok     = r.pres_s2 && (!P_NETWORK_VARIANT_PORT || r.sig_s2);

  // Single FIFO keeps buffers strictly in request order
  icm_fifo #(.W(W_CHAR), .D(P_DEPTH)) u_txq (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_flush (flush),
    .i_valid (in_ok),
    .i_data  (i_cd_data),
    .o_ready (fifo_rdy),
    .o_valid (o_link_valid),
    .o_data  (o_link_data),
    .i_ready (i_link_ready),
    .o_free  (free)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    s = r;
    rv = 1'b0;
    rc = RSP_GOOD;
    flush = 1'b0;
    s.conn_ind = 1'b0;
    s.disc_ind = 1'b0;
    s.rcvd_ind = 1'b0;
    s.rd_vld   = 1'b0;
    // Pins pass two flops; edge detect compares the second with a third
    s.pres_s1 = i_drive_side_presence_line_alt;
    s.pres_s2 = r.pres_s1;
    s.pres_d  = r.pres_s2;
    s.sig_s1  = i_link_signal;
    s.sig_s2  = r.sig_s1;
    // Request decode, one response per request
    if (take) begin
      rv = 1'b1;
      case (i_req.op)
        OP_CONNECT, OP_LISTEN: begin
          if (i_req.lport != P_LOCAL_PORT) begin
            rc = RSP_BAD_LOCAL;
          end else if (r.st == state_link_open) begin
            rc = RSP_LOCAL_IN_USE;
          end else if (i_req.op == OP_LISTEN && r.st != state_idle_unlinked) begin
            rc = RSP_NOT_ALLOWED;
          end else if (r.st == state_link_opening || r.closing) begin
            rc = RSP_NOT_ALLOWED;
          end else if (P_NETWORK_VARIANT_PORT && i_req.op == OP_CONNECT
                       && i_req.rport == PORT_NONE) begin
            rc = RSP_BAD_REMOTE;
          end else if (!phys_ok) begin
            rc = RSP_NO_PHYSICAL;
          end else if (!P_NETWORK_VARIANT_PORT) begin
            // Serial link is always there: open now, nothing sent
            s.st = state_link_open;
            s.conn_id = W_CONN'(r.conn_id + 1'b1);
            s.conn_ind = 1'b1;
          end else if (i_req.op == OP_CONNECT) begin
            s.st = state_link_opening;
            s.peer = 1'b1;
            rv = 1'b0;
          end else begin
            s.st = state_awaiting_peer;
            s.lis_rport = i_req.rport;
            s.lis_any = !i_req.rport_vld;
          end
        end
        OP_SEND: begin
          if (r.st != state_link_open) begin
            rc = RSP_NOT_CONNECTED;
          end else if (r.closing || !conn_match(i_req, r)) begin
            rc = RSP_BAD_CONN;
          end else if (!i_req.buf_ok) begin
            rc = RSP_BAD_BUFFER;
          end else if (i_req.size > W_SIZE'(free)) begin
            rc = RSP_NO_RESOURCES;
          end else if (i_req.size != '0) begin
            // Answer held back until the copy is complete
            s.copy = 1'b1;
            s.copy_left = i_req.size;
            rv = 1'b0;
          end
        end
        OP_RECEIVE: begin
          if (r.st != state_link_open) begin
            rc = RSP_NOT_CONNECTED;
          end else if (r.closing || !conn_match(i_req, r)) begin
            rc = RSP_BAD_CONN;
          end else if (!i_req.buf_ok || i_req.size == '0) begin
            rc = RSP_BAD_BUFFER;
          end else if (r.rcv_pend) begin
            rc = RSP_RECV_PENDING;
          end else begin
            s.rcv_pend = 1'b1;
            s.rcv_max = i_req.size;
            s.rcv_cnt = '0;
          end
        end
        OP_DISCONNECT: begin
          if (r.st == state_idle_unlinked || r.closing) begin
            rc = RSP_NOT_ALLOWED;
          end else if (r.st == state_link_open && !conn_match(i_req, r)) begin
            rc = RSP_BAD_CONN;
          end else begin
            s.closing = 1'b1;
            s.reason = RSN_REQUESTED;
          end
        end
        default: rc = RSP_NOT_ALLOWED;
      endcase
    end
    // Copy client characters into the port's own storage
    if (in_ok) begin
      s.copy_left = W_SIZE'(r.copy_left - 1'b1);
      if (r.copy_left == W_SIZE'(1)) begin
        s.copy = 1'b0;
        rv = 1'b1;
      end
    end
    // Peer answers on the network variant
    if (r.peer && i_peer_accept) begin
      s.st = state_link_open;
      s.peer = 1'b0;
      s.conn_id = W_CONN'(r.conn_id + 1'b1);
      s.conn_ind = 1'b1;
      rv = 1'b1;
    end else if (r.peer && i_peer_refuse) begin
      s.st = state_idle_unlinked;
      s.peer = 1'b0;
      rv = 1'b1;
      rc = RSP_REFUSED;
    end
    if (r.st == state_awaiting_peer && !r.closing && i_peer_call
        && (r.lis_any || i_peer_rport == r.lis_rport)) begin
      s.st = state_link_open;
      s.conn_id = W_CONN'(r.conn_id + 1'b1);
      s.conn_ind = 1'b1;
    end
    // Delivery ends at the maximum or when the link pauses
    if (i_rx_valid && o_rx_ready) begin
      s.rd_vld = 1'b1;
      s.rd_data = i_rx_data;
      s.rcv_cnt = W_SIZE'(r.rcv_cnt + 1'b1);
    end else if (r.rcv_pend && r.rcv_cnt != '0
                 && (r.rcv_cnt == r.rcv_max || !i_rx_valid)) begin
      s.rcvd_ind = 1'b1;
      s.rcvd_cnt = r.rcv_cnt;
      s.rcv_pend = 1'b0;
      s.rcv_cnt = '0;
    end
    // Loss of the link closes at once and drops queued characters
    if (r.st != state_idle_unlinked && (!r.closing || r.reason == RSN_REQUESTED)) begin
      if (P_NETWORK_VARIANT_PORT && !r.sig_s2) begin
        s.closing = 1'b1;
        s.reason = RSN_LOST_SIG;
      end else if (P_DROP_ON_PRESENCE && r.pres_d && !r.pres_s2) begin
        s.closing = 1'b1;
        s.reason = RSN_SENSE;
      end else if (P_NETWORK_VARIANT_PORT && i_peer_closed) begin
        s.closing = 1'b1;
        s.reason = RSN_CLOSED;
      end
      if (s.closing && s.reason != RSN_REQUESTED) begin
        flush = 1'b1;
        if (r.copy || r.peer) begin
          s.copy = 1'b0;
          s.peer = 1'b0;
          rv = 1'b1;
          rc = RSP_NO_PHYSICAL;
        end
      end
    end
    // Requested close drains transmit first; any close drains receive
    if (r.closing && !r.copy
        && (!o_link_valid || r.reason != RSN_REQUESTED)) begin
      if (r.rcv_cnt != '0) begin
        s.rcvd_ind = 1'b1;
        s.rcvd_cnt = r.rcv_cnt;
        s.rcv_cnt = '0;
      end else begin
        s.disc_ind = 1'b1;
        s.st = state_idle_unlinked;
        s.closing = 1'b0;
        s.rcv_pend = 1'b0;
      end
    end
    s.rsp_vld = rv;
    if (rv) s.rsp_code = rc;
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) r <= ST_RESET;
    else          r <= s;
  end
  // Outputs straight from state flops
  assign o_rsp_valid   = r.rsp_vld;
  assign o_rsp_code    = r.rsp_code;
  assign o_conn_ind    = r.conn_ind;
  assign o_conn_id     = r.conn_id;
  assign o_disc_ind    = r.disc_ind;
  assign o_disc_reason = r.reason;
  assign o_rd_valid    = r.rd_vld;
  assign o_rd_data     = r.rd_data;
  assign o_rcvd_ind    = r.rcvd_ind;
  assign o_rcvd_count  = r.rcvd_cnt;
  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  AST_CONNECT_STATE: assert property (
    take && i_req.op == OP_CONNECT && i_req.lport == P_LOCAL_PORT
    && r.st == state_link_opening |=> o_rsp_valid && o_rsp_code == RSP_NOT_ALLOWED)
    else $error("connect while opening not refused");
  AST_LISTEN_TO_OPENING: assert property (
    take && P_NETWORK_VARIANT_PORT && i_req.op == OP_CONNECT && phys_ok && !r.closing
    && i_req.lport == P_LOCAL_PORT && i_req.rport != PORT_NONE
    && r.st == state_awaiting_peer |=> r.st == state_link_opening && !o_rsp_valid)
    else $error("connect from awaiting did not open");
  AST_IN_USE: assert property (
    take && (i_req.op == OP_CONNECT || i_req.op == OP_LISTEN)
    && i_req.lport == P_LOCAL_PORT && r.st == state_link_open
    |=> o_rsp_code == RSP_LOCAL_IN_USE)
    else $error("second connection not refused");
  AST_NO_PHYS: assert property (
    take && i_req.op == OP_CONNECT && r.st == state_idle_unlinked && !r.closing
    && i_req.lport == P_LOCAL_PORT && !phys_ok
    && (!P_NETWORK_VARIANT_PORT || i_req.rport != PORT_NONE)
    |=> o_rsp_code == RSP_NO_PHYSICAL && r.st == state_idle_unlinked)
    else $error("connect without physical link");
  AST_CONN_CAUSE: assert property (
    o_conn_ind |-> $past(r.st) != state_idle_unlinked || $past(take))
    else $error("connected without a request");
  AST_NOT_CONN: assert property (
    take && (i_req.op == OP_SEND || i_req.op == OP_RECEIVE)
    && r.st != state_link_open |=> o_rsp_code == RSP_NOT_CONNECTED)
    else $error("transfer outside open state accepted");
  AST_RCV_PEND: assert property (
    take && i_req.op == OP_RECEIVE && r.rcv_pend && r.st == state_link_open
    && !r.closing && conn_match(i_req, r) && i_req.buf_ok && i_req.size != '0
    |=> o_rsp_code == RSP_RECV_PENDING)
    else $error("second receive accepted");
  AST_RCVD_MAX: assert property (
    o_rcvd_ind |-> o_rcvd_count != '0 && o_rcvd_count <= r.rcv_max)
    else $error("received count out of range");
  AST_NO_RCVD_AFTER: assert property (
    o_disc_ind |-> !r.rcv_pend ##1 !o_rcvd_ind)
    else $error("received after disconnected");
  AST_DRAIN: assert property (
    o_disc_ind |-> $past(r.rcv_cnt) == '0)
    else $error("disconnected before hand-over");
  AST_SERIAL_NOW: assert property (
    take && !P_NETWORK_VARIANT_PORT && i_req.op == OP_CONNECT && phys_ok
    && r.st == state_idle_unlinked && !r.closing && i_req.lport == P_LOCAL_PORT
    |=> o_conn_ind && o_rsp_valid && o_rsp_code == RSP_GOOD)
    else $error("serial connect not immediate");
  AST_LOSS: assert property (
    P_NETWORK_VARIANT_PORT && r.st != state_idle_unlinked && !r.closing && !r.sig_s2
    |=> r.closing && r.reason == RSN_LOST_SIG)
    else $error("signal loss ignored");
  COV_OPEN: cover property (o_conn_ind ##[1:50] o_rcvd_ind);
  COV_SEND: cover property (take && i_req.op == OP_SEND ##[1:40] o_rsp_valid);
  COV_CLOSE: cover property (o_rcvd_ind ##[1:20] o_disc_ind);
endmodule : icm_port

`default_nettype wire

//--- logic/icm_pkg.sv
// Types and constants shared by the interconnect connection manager.
// Assumes a single clock domain and a client on the same clock.
package icm_pkg;
  // ==========================================================
  // Widths and depths
  localparam int W_PORT     = 4;
  localparam int W_SIZE     = 8;
  localparam int W_CHAR     = 8;
  localparam int W_CONN     = 4;
  localparam int FIFO_DEPTH = 32;
  localparam logic [W_PORT-1:0] PORT_NONE = 4'h0; // Remote port 0 is refused only for a network-variant connect

  // ==========================================================
  // Connection states, Gray along idle-await-opening-open
  typedef enum logic [1:0] {
    state_idle_unlinked = 2'h0,
    state_awaiting_peer = 2'h1,
    state_link_opening  = 2'h3,
    state_link_open     = 2'h2
  } icm_conn_e;

  typedef enum logic [2:0] {
    OP_CONNECT    = 3'h0,
    OP_LISTEN     = 3'h1,
    OP_SEND       = 3'h2,
    OP_RECEIVE    = 3'h3,
    OP_DISCONNECT = 3'h4
  } icm_op_e;

  typedef enum logic [3:0] {
    RSP_GOOD          = 4'h0,
    RSP_BAD_LOCAL     = 4'h1,
    RSP_LOCAL_IN_USE  = 4'h2,
    RSP_BAD_REMOTE    = 4'h3,
    RSP_REFUSED       = 4'h4,
    RSP_NO_PHYSICAL   = 4'h5,
    RSP_NOT_ALLOWED   = 4'h6,
    RSP_BAD_CONN      = 4'h7,
    RSP_BAD_BUFFER    = 4'h8,
    RSP_NO_RESOURCES  = 4'h9,
    RSP_RECV_PENDING  = 4'ha,
    RSP_NOT_CONNECTED = 4'hb
  } icm_rsp_e;

  typedef enum logic [1:0] {
    RSN_REQUESTED = 2'h0,
    RSN_CLOSED    = 2'h1,
    RSN_SENSE     = 2'h2,
    RSN_LOST_SIG  = 2'h3
  } icm_reason_e;

  // ==========================================================
  // Service request carrier
  typedef struct packed {
    icm_op_e           op;
    logic [W_PORT-1:0] lport;
    logic [W_PORT-1:0] rport;
    logic              rport_vld;
    logic [W_CONN-1:0] conn;
    logic              buf_ok;
    logic [W_SIZE-1:0] size;
  } icm_req_s;

  // Whole state of the manager
  typedef struct packed {
    icm_conn_e         st;
    logic              closing;
    icm_reason_e       reason;
    logic              copy;
    logic              peer;
    logic [W_SIZE-1:0] copy_left;
    logic [W_CONN-1:0] conn_id;
    logic [W_PORT-1:0] lis_rport;
    logic              lis_any;
    logic              rcv_pend;
    logic [W_SIZE-1:0] rcv_max;
    logic [W_SIZE-1:0] rcv_cnt;
    logic              rsp_vld;
    icm_rsp_e          rsp_code;
    logic              conn_ind;
    logic              disc_ind;
    logic              rcvd_ind;
    logic [W_SIZE-1:0] rcvd_cnt;
    logic              rd_vld;
    logic [W_CHAR-1:0] rd_data;
    logic              pres_s1;
    logic              pres_s2;
    logic              pres_d;
    logic              sig_s1;
    logic              sig_s2;
  } icm_st_s;

  localparam icm_st_s ST_RESET = '0;
endpackage : icm_pkg

//--- logic/icm_port_unused_guard.sv
// Holds no logic; the port and its transmit FIFO live in icm_port.sv.

//--- test/icm_link_model.sv
// Far-side model of the serial link: character sink and source.
// Assumes the port's clock; strobes move on the falling edge.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Link partner
module icm_link_model
  import icm_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_stall,
  input  wire logic              i_link_valid,
  input  wire logic [W_CHAR-1:0] i_link_data,
  output logic                   o_link_ready,
  output logic                   o_rx_valid,
  output logic [W_CHAR-1:0]      o_rx_data,
  input  wire logic              i_rx_ready,
  output logic                   o_link_signal,
  output logic                   o_peer_quiet
);
  logic [W_CHAR-1:0] got_q [$];

  // Serial far side never calls, accepts or closes
  assign o_link_signal = 1'b1;
  assign o_peer_quiet  = 1'b0;
  assign o_link_ready  = !i_stall;

  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
  end

  // Collect what leaves the port, in order
  always @(posedge i_clock) begin
    if (i_link_valid === 1'b1 && o_link_ready) got_q.push_back(i_link_data);
  end

  // Emit n characters; released data line turns over so stale bytes show
  task automatic emit(input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge i_clock);
      o_rx_valid = 1'b1;
      o_rx_data  = 8'h40 + 8'(k);
      do @(posedge i_clock); while (i_rx_ready !== 1'b1);
    end
    @(negedge i_clock);
    o_rx_valid = 1'b0;
    o_rx_data  = ~o_rx_data;
  endtask : emit
endmodule : icm_link_model

`default_nettype wire

//--- test/icm_port_tb.sv
// Self-checking bench for the serial variant of the connection manager.
// Assumes a 100 ns clock; all inputs move on the falling edge.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Bench top
module icm_port_tb
  import icm_pkg::*;
;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_req_valid = 1'b0, i_cd_valid = 1'b0;
  logic pres = 1'b1, stall = 1'b0, bk = 1'b1;
  icm_req_s i_req = '0;
  logic [W_CHAR-1:0] i_cd_data = 8'h00, base = 8'h00, last_cnt = 8'h00, last_rd = 8'h00;
  logic [W_PORT-1:0] lp = 4'h1, cn = 4'h0;
  icm_reason_e last_rsn = RSN_CLOSED;
  int error_cnt = 0, n_compared = 0, n_conn = 0, n_disc = 0, n_rcvd = 0, n_rd = 0;
  wire logic o_req_ready, o_rsp_valid, o_conn_ind, o_disc_ind, o_cd_ready, o_link_valid;
  wire logic o_rx_ready, o_rd_valid, o_rcvd_ind, link_ready, rx_valid, lsig, quiet;
  wire icm_rsp_e o_rsp_code;
  wire icm_reason_e o_disc_reason;
  wire logic [W_CONN-1:0] o_conn_id;
  wire logic [W_CHAR-1:0] o_link_data, o_rd_data, rx_data;
  wire logic [W_SIZE-1:0] o_rcvd_count;

  icm_port dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
    .o_rsp_code(o_rsp_code), .o_conn_ind(o_conn_ind), .o_conn_id(o_conn_id),
    .o_disc_ind(o_disc_ind), .o_disc_reason(o_disc_reason), .i_cd_valid(i_cd_valid),
    .i_cd_data(i_cd_data), .o_cd_ready(o_cd_ready), .o_link_valid(o_link_valid),
    .o_link_data(o_link_data), .i_link_ready(link_ready), .i_rx_valid(rx_valid),
    .i_rx_data(rx_data), .o_rx_ready(o_rx_ready), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .o_rcvd_ind(o_rcvd_ind), .o_rcvd_count(o_rcvd_count),
    .i_drive_side_presence_line_alt(pres), .i_link_signal(lsig), .i_peer_accept(quiet),
    .i_peer_refuse(quiet), .i_peer_call(quiet), .i_peer_rport({4{quiet}}),
    .i_peer_closed(quiet));

  icm_link_model lm (.i_clock(i_clock), .i_stall(stall), .i_link_valid(o_link_valid),
    .i_link_data(o_link_data), .o_link_ready(link_ready), .o_rx_valid(rx_valid),
    .o_rx_data(rx_data), .i_rx_ready(o_rx_ready), .o_link_signal(lsig),
    .o_peer_quiet(quiet));

  always #50 i_clock = ~i_clock;

  // Count one-cycle indications as they pass
  always @(posedge i_clock) begin
    if (o_conn_ind === 1'b1) n_conn++;
    if (o_rd_valid === 1'b1) begin
      n_rd++;
      last_rd = o_rd_data;
    end
    if (o_disc_ind === 1'b1) begin
      n_disc++;
      last_rsn = o_disc_reason;
    end
    if (o_rcvd_ind === 1'b1) begin
      n_rcvd++;
      last_cnt = o_rcvd_count;
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One request held until taken; send characters fed until the answer
  task automatic req(input icm_op_e op, input logic [7:0] sz, input icm_rsp_e exp);
    int k;
    int sent;
    k = 0;
    sent = 0;
    @(negedge i_clock);
    i_req = '{op, lp, 4'h9, 1'b0, cn, bk, sz};
    i_req_valid = 1'b1;
    do @(posedge i_clock); while (o_req_ready !== 1'b1 && k++ < 300);
    do begin
      @(negedge i_clock);
      i_req_valid = 1'b0;
      i_cd_valid = (op == OP_SEND) && (sent < sz);
      i_cd_data = base + 8'(sent);
      @(posedge i_clock);
      if (i_cd_valid && o_cd_ready === 1'b1) sent++;
    end while (o_rsp_valid !== 1'b1 && k++ < 300);
    chk("rsp valid", 8'd1, {7'h0, o_rsp_valid});
    chk(op.name(), {4'h0, exp}, {4'h0, o_rsp_code});
    // Scribble the client bytes: copies already taken must not change
    @(negedge i_clock);
    i_cd_valid = 1'b0;
    i_cd_data = 8'hee;
  endtask : req

  task automatic wt(ref int c, input int v);
    repeat (300) if (c < v) @(posedge i_clock);
  endtask : wt

  task automatic t_idle;
    req(OP_SEND, 8'd1, RSP_NOT_CONNECTED);
    req(OP_RECEIVE, 8'd3, RSP_NOT_CONNECTED);
    req(OP_DISCONNECT, 8'd0, RSP_NOT_ALLOWED);
    lp = 4'h2;
    req(OP_CONNECT, 8'd0, RSP_BAD_LOCAL);
    lp = 4'h1;
    chk("conn ind", 8'd0, 8'(n_conn));
    $display("test idle done");
  endtask : t_idle

  task automatic t_open;
    req(OP_CONNECT, 8'd0, RSP_GOOD);
    chk("conn ind", 8'd1, 8'(n_conn));
    chk("conn id", 8'd1, {4'h0, o_conn_id});
    req(OP_CONNECT, 8'd0, RSP_LOCAL_IN_USE);
    req(OP_LISTEN, 8'd0, RSP_LOCAL_IN_USE);
    chk("link quiet", 8'd0, 8'(lm.got_q.size()));
    cn = 4'h1;
    $display("test open done");
  endtask : t_open

  task automatic t_send;
    logic [7:0] ex [5] = '{8'h10, 8'h11, 8'h12, 8'h20, 8'h21};
    stall = 1'b1;
    base = 8'h10;
    req(OP_SEND, 8'd3, RSP_GOOD);
    base = 8'h20;
    req(OP_SEND, 8'd2, RSP_GOOD);
    req(OP_SEND, 8'd28, RSP_NO_RESOURCES);
    bk = 1'b0;
    req(OP_SEND, 8'd1, RSP_BAD_BUFFER);
    bk = 1'b1;
    cn = 4'h4;
    req(OP_SEND, 8'd1, RSP_BAD_CONN);
    cn = 4'h1;
    req(OP_RECEIVE, 8'd0, RSP_BAD_BUFFER);
    stall = 1'b0;
    repeat (12) @(posedge i_clock);
    chk("link count", 8'd5, 8'(lm.got_q.size()));
    foreach (ex[i]) chk("link char", ex[i], lm.got_q[i]);
    $display("test send done");
  endtask : t_send

  task automatic t_recv;
    req(OP_RECEIVE, 8'd3, RSP_GOOD);
    req(OP_RECEIVE, 8'd3, RSP_RECV_PENDING);
    fork
      lm.emit(5);
    join_none
    wt(n_rcvd, 1);
    chk("rcvd count", 8'd3, last_cnt);
    chk("rd data", 8'h42, last_rd);
    req(OP_RECEIVE, 8'd4, RSP_GOOD);
    wt(n_rcvd, 2);
    chk("rcvd count", 8'd2, last_cnt);
    chk("rd data", 8'h44, last_rd);
    chk("chars delivered", 8'd5, 8'(n_rd));
    $display("test receive done");
  endtask : t_recv

  task automatic t_close;
    stall = 1'b1;
    req(OP_SEND, 8'd1, RSP_GOOD);
    req(OP_DISCONNECT, 8'd0, RSP_GOOD);
    req(OP_SEND, 8'd1, RSP_BAD_CONN);
    req(OP_DISCONNECT, 8'd0, RSP_NOT_ALLOWED);
    stall = 1'b0;
    wt(n_disc, 1);
    chk("disc reason", {6'h0, RSN_REQUESTED}, {6'h0, last_rsn});
    req(OP_LISTEN, 8'd0, RSP_GOOD);
    chk("conn ind", 8'd2, 8'(n_conn));
    chk("conn id", 8'd2, {4'h0, o_conn_id});
    chk("rcvd after close", 8'd2, 8'(n_rcvd));
    cn = 4'h2;
    $display("test close done");
  endtask : t_close

  task automatic t_loss;
    pres = 1'b0;
    wt(n_disc, 2);
    chk("disc reason", {6'h0, RSN_SENSE}, {6'h0, last_rsn});
    req(OP_CONNECT, 8'd0, RSP_NO_PHYSICAL);
    $display("test loss done");
  endtask : t_loss

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // Main sequence; pins need three edges after release
  initial begin
    repeat (8) @(negedge i_clock);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_clock);
    t_idle();
    t_open();
    t_send();
    t_recv();
    t_close();
    t_loss();
    stop_test();
  end

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (20000) @(posedge i_clock);
    error_cnt++;
    stop_test();
  end
endmodule : icm_port_tb

`default_nettype wire
